// >>> common/dma_seq_defs.vh
// register offsets, field positions, reset values and timing counts of the dma sequencer
`ifndef DMA_SEQ_DEFS_VH
`define DMA_SEQ_DEFS_VH

// register byte offsets
`define OFS_MAIN 8'h00
`define OFS_FEAT 8'h04
`define OFS_BURST 8'h08
`define OFS_ACT 8'h0C
`define OFS_IALO 8'h10
`define OFS_IAHI 8'h14
`define OFS_IIDX 8'h18
`define OFS_IDAT 8'h1C
`define OFS_PER 8'h20
`define OFS_SCFG 8'h24

// field positions
`define MAIN_INIT 0
`define MAIN_IDONE 1
`define MAIN_MASTER 2
`define FEAT_TIMER 13
`define FEAT_EXT 14
`define SCFG_IO16 6

// reset values
`define BURST_RST 8'h10
`define ACT_RST 16'h000A
`define SCFG_RST 7'h00

// operation kinds from buffer management
`define KIND_DRD 2'h0
`define KIND_DWR 2'h1
`define KIND_FRD 2'h2
`define KIND_FWR 2'h3

// initialization block size
`define INIT_WORDS 12
`define INIT_LAST 4'hB

// timing
`define CLK_MHZ 50
`define TICK_NS 100
`define TICK_CYC ((`TICK_NS * `CLK_MHZ + 999) / 1000)
`define STRB_NS 100
`define STRB_CYC ((`STRB_NS * `CLK_MHZ + 999) / 1000)
`define HOLD_NS 1000
`define HOLD_CYC ((`HOLD_NS * `CLK_MHZ) / 1000)

`endif

// >>> hdl/init_block_mem.v
// twelve-word store for the fetched initialization block
`timescale 1ns/1ps
`include "dma_seq_defs.vh"
module init_block_mem (
  input wire pclk, // clock
  input wire we, // write strobe
  input wire [3:0] waddr, // write word index
  input wire [15:0] wdata, // write data
  input wire [3:0] raddr, // read word index
  output reg [15:0] rdata_r // registered read data
);
  reg [15:0] mem [0:`INIT_WORDS-1];

  // write port; out-of-range indices are dropped
  always @(posedge pclk)
  begin
    if (we && (waddr <= `INIT_LAST))
      mem[waddr] <= wdata;
  end

  // registered read; out of range reads zero
  always @(posedge pclk)
  begin
    if (raddr <= `INIT_LAST)
      rdata_r <= mem[raddr];
    else
      rdata_r <= 16'h0000;
  end
endmodule // init_block_mem

// >>> hdl/isa_dma_seq.v
// bus interface sequencer: apb registers, isa master cycles, slave response
// Functional notes
// - initialization fetch reads exactly twelve words into internal storage.
// - timer off: init fetch uses three periods of four contiguous words.
// - timer on: init fetch in 1-3 periods, four-word chunks, more if time allows.
// - descriptor read order is word 1, word 0, word 2.
// - write-back to unchained or end-of-packet descriptor writes word 1 then 3.
// - write-back to chained descriptor without end-of-packet writes word 1 only.
// - descriptor writes drive SA0 and SBHE to update only needed bytes.
// - timer off: one descriptor, one direction per period, 3/2/1 cycles.
// - timer on: any mix of descriptor and buffer accesses per period.
// - fifo grant gives a run of back-to-back cycles before release.
// - timer off: fifo transfers one direction, ascending adjacent addresses.
// - timer on: fifo transfers may mix directions and addresses.
// - ext burst off: fifo transfers capped by burst limit, default 16.
// - burst limit is only a ceiling; fifo state may end earlier.
// - ext burst on, timer off: run until fifo threshold ends it.
// - timer on: period ends when work is done or activity limit expires.
// - timer on: buffer work limited by burst limit only when ext off.
// - timer on: hold bus about 1 us for more work, then release.
// - IOCS16 follows decoded inputs combinationally.
// - IOCHRDY pulled low asynchronously, released on the clock.
// - all master signals change on the internal clock.
// - init fetch starts from the init command bit, address from two registers.
// - descriptors are four words; ring bases are eight-byte aligned.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dma_seq_defs.vh"
module isa_dma_seq (
  input wire pclk, // clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error, unmapped offset
  output wire bus_req, // bus ownership request
  input wire bus_grant, // ownership grant
  output wire [23:0] sa_out, // master address, bit 0 is SA0
  output wire sbhe_n_out, // high byte enable, active low
  output wire memr_n_out, // memory read strobe
  output wire memw_n_out, // memory write strobe
  output wire master_oe_n, // master address/strobe enable, low drives
  input wire [15:0] sd_in, // data bus in
  output wire [15:0] sd_out, // data bus out
  output wire sd_oe_n, // data enable, low drives
  input wire iochrdy_in, // memory ready during master cycles
  input wire aen, // address enable
  input wire [9:4] sa_in, // slave io address
  input wire ior_n, // io read strobe
  input wire iow_n, // io write strobe
  input wire slave_ready, // internal slave access can complete
  output wire iocs16_n, // 16-bit select
  output wire iochrdy_oe_n, // wait pull enable, low pulls
  input wire op_valid, // buffer management request, held to done
  input wire [1:0] op_kind, // request kind
  input wire [23:0] op_addr, // descriptor or buffer address
  input wire op_chained, // descriptor is chained
  input wire op_enp, // end_of_packet_flag of descriptor
  input wire [1:0] op_be1, // byte lanes for word 1 write
  input wire [1:0] op_be3, // byte lanes for word 3 write
  input wire [15:0] op_wdata1, // word 1 write data
  input wire [15:0] op_wdata3, // word 3 write data
  input wire [15:0] fifo_wdata, // receive fifo word
  input wire fifo_more, // fifo wants a further word
  output wire op_done, // request complete pulse
  output wire rd_valid, // read word pulse
  output wire [15:0] rd_data, // read word
  output wire [1:0] rd_word, // descriptor word index of read
  output wire fifo_pop // receive fifo word consumed pulse
);
  localparam ST_IDLE = 3'd0;
  localparam ST_REQ = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_STRB = 3'd3;
  localparam ST_DONE = 3'd4;
  localparam ST_HOLD = 3'd5;
  localparam ST_REL = 3'd6;
  localparam integer TICK_N = `TICK_CYC - 1;
  localparam integer STRB_N = `STRB_CYC - 1;
  localparam integer HOLD_N = `HOLD_CYC - 1;
  localparam [2:0] TICK_LAST = TICK_N[2:0];
  localparam [2:0] STRB_LAST = STRB_N[2:0];
  localparam [5:0] HOLD_LAST = HOLD_N[5:0];

  // descriptor word order for each step
  function [1:0] desc_word;
    input rd;
    input [1:0] step;
    begin
      if (rd)
        desc_word = (step == 2'h0) ? 2'h1 : ((step == 2'h1) ? 2'h0 : 2'h2);
      else
        desc_word = (step == 2'h0) ? 2'h1 : 2'h3;
    end
  endfunction

  reg [31:0] prdata_r, rd_mux;
  reg pready_r, pslverr_r, init_pend_r, init_done_r, timer_en_r, ext_r, act_r, isinit_r;
  reg bus_req_r, sbhe_n_r, memr_n_r, memw_n_r, moe_n_r, sd_oe_n_r;
  reg op_done_r, rd_valid_r, fifo_pop_r, last, rd_hit;
  reg [7:0] burst_r, iahi_r, pcnt_r;
  reg [15:0] act_lim_r, ialo_r, per_cnt_r, wcnt_r, act_cnt_r, sd_out_r, rdat_r;
  reg [3:0] iidx_r;
  reg [6:0] scfg_r;
  reg [2:0] state_r, strb_cnt_r, tick_r;
  reg [5:0] hold_cnt_r;
  reg [23:0] sa_r;
  reg [1:0] rd_word_r;
  wire [15:0] imem_q;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign bus_req = bus_req_r;
  assign sa_out = sa_r;
  assign sbhe_n_out = sbhe_n_r;
  assign memr_n_out = memr_n_r;
  assign memw_n_out = memw_n_r;
  assign master_oe_n = moe_n_r;
  assign sd_out = sd_out_r;
  assign sd_oe_n = sd_oe_n_r;
  assign op_done = op_done_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rdat_r;
  assign rd_word = rd_word_r;
  assign fifo_pop = fifo_pop_r;

  // current word: kind, address, lanes and data
  wire is_fifo = ~isinit_r & op_kind[1];
  wire cur_wr = ~isinit_r & op_kind[0];
  wire [1:0] dword = desc_word(op_kind == `KIND_DRD, wcnt_r[1:0]);
  wire [23:0] ibase = {iahi_r, ialo_r[15:1], 1'b0};
  wire [23:0] dbase = {op_addr[23:3], 3'b000};
  wire [23:0] wbase = isinit_r ? ibase : (is_fifo ? op_addr : dbase);
  wire [15:0] woff = (isinit_r | is_fifo) ? wcnt_r : {14'h0000, dword};
  // ascending adjacent words for init and fifo runs
  wire [23:0] cur_addr = wbase + {7'h00, woff, 1'b0};
  wire [1:0] cur_be = (cur_wr & ~is_fifo) ? ((dword == 2'h3) ? op_be3 : op_be1) : 2'b11;
  wire [15:0] cur_wdat = is_fifo ? fifo_wdata : ((dword == 2'h3) ? op_wdata3 : op_wdata1);

  // bus activity limit, counted in ticks from the grant
  wire expired = timer_en_r & (act_cnt_r >= act_lim_r);
  // burst limit counts buffer words of this period, only with ext burst off
  wire limit_hit = ~ext_r & ({1'b0, pcnt_r} + 9'h001 >= {1'b0, burst_r});
  wire hold_ok = (state_r == ST_HOLD) & ~expired & (hold_cnt_r != HOLD_LAST);
  wire take_ok = ((state_r == ST_IDLE) & ~act_r) | hold_ok;
  wire init_take = take_ok & init_pend_r;
  wire op_take = take_ok & ~init_pend_r & op_valid & ~op_done_r;
  wire word_end = (state_r == ST_DONE);
  wire init_fin = word_end & isinit_r & last;
  wire grant_evt = (state_r == ST_REQ) & bus_grant & bus_req_r;
  wire owning = ~moe_n_r;
  wire apb_acc = psel & penable;
  wire apb_fin = apb_acc & pready_r;
  wire apb_wr = apb_fin & pwrite;

  // does this word end the whole operation
  always @*
  begin
    last = 1'b0;
    if (isinit_r)
      last = (wcnt_r[3:0] == `INIT_LAST);
    else
    begin
      case (op_kind)
        `KIND_DRD: last = (wcnt_r[1:0] == 2'h2);
        `KIND_DWR: last = (op_enp | ~op_chained) ? (wcnt_r[1:0] == 2'h1) : 1'b1;
        // fifo state may end the run well before the ceiling
        default: last = ~fifo_more | limit_hit;
      endcase
    end
  end

  // break between words: init at four-word chunks, fifo on expiry
  wire brk = isinit_r ? ((wcnt_r[1:0] == 2'h3) & (~timer_en_r | expired)) :
    (is_fifo & timer_en_r & expired);

  // activity tick divider and counter, restarted at each grant
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_r <= 3'd0;
      act_cnt_r <= 16'h0000;
    end
    else if (grant_evt)
    begin
      tick_r <= 3'd0;
      act_cnt_r <= 16'h0000;
    end
    else if (owning)
    begin
      if (tick_r == TICK_LAST)
      begin
        tick_r <= 3'd0;
        if (act_cnt_r != 16'hFFFF)
          act_cnt_r <= act_cnt_r + 16'h0001;
      end
      else
        tick_r <= tick_r + 3'd1;
    end
  end

  // master sequencer: every output changes only on the clock edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      act_r <= 1'b0;
      isinit_r <= 1'b0;
      wcnt_r <= 16'h0000;
      pcnt_r <= 8'h00;
      strb_cnt_r <= 3'd0;
      hold_cnt_r <= 6'd0;
      bus_req_r <= 1'b0;
      sa_r <= 24'h000000;
      sbhe_n_r <= 1'b1;
      memr_n_r <= 1'b1;
      memw_n_r <= 1'b1;
      moe_n_r <= 1'b1;
      sd_out_r <= 16'h0000;
      sd_oe_n_r <= 1'b1;
      rdat_r <= 16'h0000;
      op_done_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_word_r <= 2'h0;
      fifo_pop_r <= 1'b0;
      per_cnt_r <= 16'h0000;
    end
    else
    begin
      op_done_r <= 1'b0;
      rd_valid_r <= 1'b0;
      fifo_pop_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (act_r)
            state_r <= ST_REQ;
          else if (init_take | op_take)
          begin
            act_r <= 1'b1;
            isinit_r <= init_take;
            wcnt_r <= 16'h0000;
            state_r <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          // no cycle is driven before the grant arrives
          bus_req_r <= 1'b1;
          if (grant_evt)
          begin
            moe_n_r <= 1'b0;
            pcnt_r <= 8'h00;
            per_cnt_r <= per_cnt_r + 16'h0001;
            state_r <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          // a lone high byte sets SA0; SBHE whenever the high lane is enabled, which includes every read
          sa_r <= {cur_addr[23:1], ~cur_be[0]};
          sbhe_n_r <= ~cur_be[1];
          sd_out_r <= cur_wdat;
          sd_oe_n_r <= ~cur_wr;
          memr_n_r <= cur_wr;
          memw_n_r <= ~cur_wr;
          strb_cnt_r <= 3'd0;
          state_r <= ST_STRB;
        end
        ST_STRB:
        begin
          if (strb_cnt_r != STRB_LAST)
            strb_cnt_r <= strb_cnt_r + 3'd1;
          else if (iochrdy_in)
          begin
            rdat_r <= sd_in;
            memr_n_r <= 1'b1;
            memw_n_r <= 1'b1;
            state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          sd_oe_n_r <= 1'b1;
          pcnt_r <= pcnt_r + {7'h00, is_fifo};
          rd_valid_r <= ~isinit_r & ~cur_wr;
          rd_word_r <= dword;
          fifo_pop_r <= is_fifo & cur_wr;
          hold_cnt_r <= 6'd0;
          if (last)
          begin
            act_r <= 1'b0;
            op_done_r <= ~isinit_r;
            wcnt_r <= 16'h0000;
            // timer off: one operation per period, so one descriptor, one direction
            if (timer_en_r & ~expired)
              state_r <= ST_HOLD;
            else
              state_r <= ST_REL;
          end
          else
          begin
            wcnt_r <= wcnt_r + 16'h0001;
            // back-to-back words while the run lasts
            state_r <= brk ? ST_REL : ST_ADDR;
          end
        end
        ST_HOLD:
        begin
          // idle ownership waiting for further work
          hold_cnt_r <= hold_cnt_r + 6'd1;
          if (init_take | op_take)
          begin
            act_r <= 1'b1;
            isinit_r <= init_take;
            wcnt_r <= 16'h0000;
            state_r <= ST_ADDR;
          end
          else if (~hold_ok)
            state_r <= ST_REL;
        end
        ST_REL:
        begin
          bus_req_r <= 1'b0;
          moe_n_r <= 1'b1;
          // the arbiter keeps the grant until the request is withdrawn
          if (~bus_grant & ~bus_req_r)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // apb read mux
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `OFS_MAIN: rd_mux = {29'h0, owning, init_done_r, init_pend_r | (act_r & isinit_r)};
      `OFS_FEAT: rd_mux = {17'h0, ext_r, timer_en_r, 13'h0};
      `OFS_BURST: rd_mux = {24'h0, burst_r};
      `OFS_ACT: rd_mux = {16'h0, act_lim_r};
      `OFS_IALO: rd_mux = {16'h0, ialo_r};
      `OFS_IAHI: rd_mux = {24'h0, iahi_r};
      `OFS_IIDX: rd_mux = {28'h0, iidx_r};
      `OFS_IDAT: rd_mux = {16'h0, imem_q};
      `OFS_PER: rd_mux = {16'h0, per_cnt_r};
      `OFS_SCFG: rd_mux = {25'h0, scfg_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // apb slave: one wait state, answer registered in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (apb_fin)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (apb_acc)
    begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_r <= ~rd_hit;
    end
  end

  // software registers; hardware set of init done wins over a clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_pend_r <= 1'b0;
      init_done_r <= 1'b0;
      timer_en_r <= 1'b0;
      ext_r <= 1'b0;
      burst_r <= `BURST_RST;
      act_lim_r <= `ACT_RST;
      ialo_r <= 16'h0000;
      iahi_r <= 8'h00;
      iidx_r <= 4'h0;
      scfg_r <= `SCFG_RST;
    end
    else
    begin
      if (init_take)
        init_pend_r <= 1'b0;
      else if (apb_wr && paddr == `OFS_MAIN && pwdata[`MAIN_INIT] && !(act_r & isinit_r))
        init_pend_r <= 1'b1;
      if (init_fin)
        init_done_r <= 1'b1;
      else if (apb_wr && paddr == `OFS_MAIN && pwdata[`MAIN_IDONE])
        init_done_r <= 1'b0;
      if (apb_wr)
      begin
        case (paddr)
          `OFS_FEAT:
          begin
            timer_en_r <= pwdata[`FEAT_TIMER];
            ext_r <= pwdata[`FEAT_EXT];
          end
          `OFS_BURST: burst_r <= pwdata[7:0];
          `OFS_ACT: act_lim_r <= pwdata[15:0];
          `OFS_IALO: ialo_r <= pwdata[15:0];
          `OFS_IAHI: iahi_r <= pwdata[7:0];
          `OFS_IIDX: iidx_r <= pwdata[3:0];
          `OFS_SCFG: scfg_r <= pwdata[6:0];
          default: ;
        endcase
      end
    end
  end

  // fetched init words land in their own store
  init_block_mem u_imem (
    .pclk(pclk),
    .we(word_end & isinit_r),
    .waddr(wcnt_r[3:0]),
    .wdata(rdat_r),
    .raddr(iidx_r),
    .rdata_r(imem_q)
  );

  slave_resp u_slave (
    .pclk(pclk),
    .presetn(presetn),
    .aen(aen),
    .sa_in(sa_in),
    .io_base(scfg_r[5:0]),
    .io16(scfg_r[`SCFG_IO16]),
    .ior_n(ior_n),
    .iow_n(iow_n),
    .slave_ready(slave_ready),
    .iocs16_n(iocs16_n),
    .iochrdy_oe_n(iochrdy_oe_n)
  );
endmodule // isa_dma_seq

// >>> hdl/slave_resp.v
// slave-side 16-bit select and wait-state response
`timescale 1ns/1ps
module slave_resp (
  input wire pclk, // clock
  input wire presetn, // async reset, active low
  input wire aen, // address enable, high during dma
  input wire [9:4] sa_in, // io address bits
  input wire [5:0] io_base, // decoded io base
  input wire io16, // respond as 16-bit port
  input wire ior_n, // io read strobe
  input wire iow_n, // io write strobe
  input wire slave_ready, // internal access can complete
  output wire iocs16_n, // 16-bit select, active low
  output wire iochrdy_oe_n // pulls iochrdy low when low
);
  reg rdy_r;
  wire sel = ~aen & (sa_in == io_base);
  wire access = sel & (~ior_n | ~iow_n);

  // select follows the address with no clock in the path
  assign iocs16_n = ~(sel & io16);

  // ready latch only changes on the clock, so release is synchronous
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdy_r <= 1'b0;
    else if (!access)
      rdy_r <= 1'b0;
    else if (slave_ready)
      rdy_r <= 1'b1;
  end

  // the pull starts with the strobe itself, ahead of any edge
  assign iochrdy_oe_n = ~(access & ~rdy_r);
endmodule // slave_resp

// >>> tb/host_mem_model.sv
// host memory and bus arbiter seen by the dma sequencer
`timescale 1ns/1ps
module host_mem_model (
  input wire pclk, // clock
  input wire presetn, // reset
  input wire bus_req, // request
  output reg bus_grant, // grant
  input wire [23:0] sa_out, // address, bit 0 low lane
  input wire sbhe_n_out, // high lane enable
  input wire memr_n_out, // read strobe
  input wire memw_n_out, // write strobe
  input wire [15:0] sd_out, // write data
  output wire [15:0] sd_in, // read data
  output wire iochrdy_in, // ready
  input wire [3:0] slow // wait cycles per access
);
  reg [15:0] mem [0:255];
  reg [15:0] last_r;
  reg pend_r;
  reg memw_q;
  reg [3:0] wait_r;
  integer wr_cnt;
  integer k;
  initial
    for (k = 0; k < 256; k = k + 1) mem[k] = {~k[7:0], k[7:0]};
  // released bus shows the inverse of the last word, not a held value
  assign sd_in = memr_n_out ? ~last_r : mem[sa_out[8:1]];
  assign iochrdy_in = (memr_n_out && memw_n_out) || wait_r >= slow;
  // grant two cycles after request, held until it is withdrawn
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bus_grant <= 1'b0;
      pend_r <= 1'b0;
      memw_q <= 1'b1;
      wait_r <= 4'h0;
      last_r <= 16'h0000;
      wr_cnt <= 0;
    end
    else
    begin
      pend_r <= bus_req;
      bus_grant <= bus_req && pend_r;
      memw_q <= memw_n_out;
      wait_r <= (memr_n_out && memw_n_out) ? 4'h0 : wait_r + {3'h0, wait_r != 4'hF};
      if (!memr_n_out) last_r <= mem[sa_out[8:1]];
      if (!memw_n_out && !sa_out[0]) mem[sa_out[8:1]][7:0] <= sd_out[7:0];
      if (!memw_n_out && !sbhe_n_out) mem[sa_out[8:1]][15:8] <= sd_out[15:8];
      if (!memw_n_out && memw_q) wr_cnt <= wr_cnt + 1;
    end
endmodule // host_mem_model

// >>> tb/isa_dma_seq_bench.sv
// self-checking bench for the dma sequencer
`timescale 1ns/1ps
module isa_dma_seq_bench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rdat;
  reg aen = 1'b1, ior_n = 1'b1, iow_n = 1'b1, slave_ready = 1'b0, rerr;
  reg [5:0] sa_in = 6'h00;
  reg op_valid = 1'b0, op_chained = 1'b0, op_enp = 1'b0, fifo_more = 1'b0;
  reg [1:0] op_kind = 2'h0, op_be1 = 2'h3, op_be3 = 2'h3;
  reg [23:0] op_addr = 24'h0;
  reg [15:0] op_wdata1 = 16'h0, op_wdata3 = 16'h0, fifo_wdata = 16'h0;
  reg [3:0] slow = 4'h0;
  reg [7:0] b;
  reg [15:0] got [0:15];
  reg [1:0] wrd [0:15];
  wire [31:0] prdata;
  wire pready, pslverr, bus_req, bus_grant, sbhe_n_out, memr_n_out, memw_n_out;
  wire master_oe_n, sd_oe_n, iochrdy_in, iocs16_n, iochrdy_oe_n, op_done, rd_valid, fifo_pop;
  wire [23:0] sa_out;
  wire [15:0] sd_in, sd_out, rd_data;
  wire [1:0] rd_word;
  integer mismatches = 0, total_checks = 0, cyc = 0, nrd, npop, per0, c0, i;
  // free-running clock
  always #10 pclk = ~pclk;
  isa_dma_seq isa_dma_seq_i (.*);
  host_mem_model host_mem_model_i (.*);
  // memory fill pattern, worked out apart from the model
  function [31:0] pat(input [7:0] x);
    pat = {16'h0, ~x, x};
  endfunction
  task chk(input string n, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // request held until op_done; read pulses are collected on the way
  task op(input [1:0] k, input [23:0] a, input ch, input en, input mr);
    @(posedge pclk);
    op_kind <= k;
    op_addr <= a;
    op_chained <= ch;
    op_enp <= en;
    fifo_more <= mr;
    op_valid <= 1'b1;
    nrd = 0;
    npop = 0;
    do
    begin
      @(posedge pclk);
      if (fifo_pop === 1'b1) npop = npop + 1;
      if (rd_valid === 1'b1)
      begin
        got[nrd & 15] = rd_data;
        wrd[nrd & 15] = rd_word;
        nrd = nrd + 1;
      end
    end while (op_done !== 1'b1);
    op_valid <= 1'b0;
  endtask
  task t_regs;
    rd(8'h08);
    chk("burst_limit", 32'h10, rdat);
    rd(8'h0C);
    chk("activity", 32'h000A, rdat);
    rd(8'h3C);
    chk("unmapped_err", 32'h1, rerr);
  endtask
  task t_init(input [31:0] feat, input [31:0] np);
    wr(8'h04, feat);
    wr(8'h10, 32'h40);
    wr(8'h14, 32'h0);
    rd(8'h20);
    per0 = rdat;
    wr(8'h00, 32'h1);
    i = 0;
    do
    begin
      rd(8'h00);
      i = i + 1;
    end while (rdat[1] !== 1'b1 && i < 300);
    chk("init_done", 32'h1, rdat[1]);
    rd(8'h20);
    chk("init_periods", per0 + np, rdat);
    for (i = 0; i < 12; i = i + 1)
    begin
      wr(8'h18, i);
      rd(8'h1C);
      chk("init_word", pat(8'h20 + i), rdat);
    end
    wr(8'h00, 32'h2);
  endtask
  task t_desc_rd;
    slow <= 4'h6;
    rd(8'h20);
    per0 = rdat;
    op(2'h0, 24'h000084, 1'b0, 1'b0, 1'b0);
    chk("desc_reads", 32'h3, nrd);
    for (i = 0; i < 3; i = i + 1)
    begin
      chk("desc_word", {i == 2, i == 0}, wrd[i]);
      chk("desc_data", pat(8'h40 + {i == 2, i == 0}), got[i]);
    end
    rd(8'h20);
    chk("desc_periods", per0 + 1, rdat);
    slow <= 4'h0;
  endtask
  // word 1 writes only the low lane, word 3 both lanes
  task t_desc_wr(input ch, input en, input [23:0] a, input [31:0] nw);
    c0 = host_mem_model_i.wr_cnt;
    op_be1 <= 2'h1;
    op_wdata1 <= 16'hC3C3;
    op_wdata3 <= 16'h1234;
    op(2'h1, a, ch, en, 1'b0);
    chk("desc_writes", nw, host_mem_model_i.wr_cnt - c0);
    b = a[8:1] + 8'h01;
    chk("word1_lanes", {~b, 8'hC3}, host_mem_model_i.mem[b]);
    b = a[8:1] + 8'h03;
    chk("word3", nw == 2 ? 32'h1234 : pat(b), host_mem_model_i.mem[b]);
  endtask
  task t_fifo;
    wr(8'h08, 32'h3);
    rd(8'h20);
    per0 = rdat;
    op(2'h2, 24'h0000C0, 1'b0, 1'b0, 1'b1);
    chk("fifo_count", 32'h3, nrd);
    for (i = 0; i < 3; i = i + 1)
      chk("fifo_data", pat(8'h60 + i), got[i]);
    rd(8'h20);
    chk("fifo_periods", per0 + 1, rdat);
    op(2'h2, 24'h0000D0, 1'b0, 1'b0, 1'b0);
    chk("fifo_short", 32'h1, nrd);
    fifo_wdata <= 16'hA5A5;
    op(2'h3, 24'h0000E0, 1'b0, 1'b0, 1'b0);
    chk("fifo_pop", 32'h1, npop);
    chk("fifo_wr", 32'hA5A5, host_mem_model_i.mem[8'h70]);
  endtask
  task t_slave;
    wr(8'h24, 32'h45);
    aen <= 1'b0;
    sa_in <= 6'h05;
    ior_n <= 1'b0;
    @(posedge pclk);
    chk("select", 32'h0, iocs16_n);
    chk("wait_pull", 32'h0, iochrdy_oe_n);
    slave_ready <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("wait_free", 32'h1, iochrdy_oe_n);
    ior_n <= 1'b1;
    aen <= 1'b1;
    slave_ready <= 1'b0;
    @(posedge pclk);
    chk("select_idle", 32'h1, iocs16_n);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_init(32'h0, 32'h3);
    wr(8'h0C, 32'hFFFF);
    t_init(32'h2000, 32'h1);
    wr(8'h04, 32'h0);
    t_desc_rd;
    t_desc_wr(1'b0, 1'b0, 24'h000090, 32'h2);
    t_desc_wr(1'b1, 1'b1, 24'h0000A0, 32'h2);
    t_desc_wr(1'b1, 1'b0, 24'h0000B0, 32'h1);
    t_fifo;
    t_slave;
    results;
  end
endmodule // isa_dma_seq_bench

// >>> tb/isa_dma_seq_sva.sv
// port assertions for the dma sequencer
`timescale 1ns/1ps
module isa_dma_seq_chk (
  input wire pclk, // clock
  input wire presetn, // reset
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pready, // apb ready
  input wire bus_req, // request
  input wire bus_grant, // grant
  input wire memr_n_out, // read strobe
  input wire memw_n_out, // write strobe
  input wire master_oe_n, // master drive
  input wire sd_oe_n, // data drive
  input wire aen, // address enable
  input wire iocs16_n, // 16-bit select
  input wire iochrdy_oe_n, // wait pull
  input wire slave_ready, // slave done
  input wire op_valid, // request valid
  input wire [1:0] op_kind, // request kind
  input wire rd_valid, // read pulse
  input wire [1:0] rd_word // word index
);
  reg [1:0] last_r; // previous read word
  wire drd = op_valid && op_kind == 2'h0; // descriptor read running
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // keeps the last word so the read order spans pulses
  always @(posedge pclk or negedge presetn)
    if (!presetn) last_r <= 2'h3;
    else if (rd_valid) last_r <= rd_word;
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_strobe;
    !memr_n_out [*5];
  endsequence
  a_apb_one_wait: assert property ($rose(penable) && psel |=> s_answer)
    else $error("apb answer late or long");
  a_no_ungranted: assert property (!master_oe_n |-> bus_grant)
    else $error("bus driven without grant");
  a_idle_quiet: assert property (!bus_req |-> master_oe_n && memr_n_out && memw_n_out)
    else $error("master active without request");
  a_strobe_len: assert property ($fell(memr_n_out) |-> s_strobe)
    else $error("read strobe too short");
  a_data_owned: assert property (!sd_oe_n |-> !master_oe_n)
    else $error("data driven while not master");
  a_desc_word0: assert property (rd_valid && drd && rd_word == 2'h0 |-> last_r == 2'h1)
    else $error("word 0 not after word 1");
  a_desc_word2: assert property (rd_valid && drd && rd_word == 2'h2 |-> last_r == 2'h0)
    else $error("word 2 not after word 0");
  a_select_idle: assert property (aen |-> iocs16_n)
    else $error("select during dma");
  a_wait_release: assert property (slave_ready && !iochrdy_oe_n |=> iochrdy_oe_n)
    else $error("wait not released");
endmodule // isa_dma_seq_chk
bind isa_dma_seq isa_dma_seq_chk isa_dma_seq_chk_i (.*);
